//--- bpr_pkg.sv
// constants and types for the branch predictor and return-address stack
// Function
// - history is kept for at most three near branches per 16-byte fetch window.
// - a branch straddling a 16-byte boundary belongs to the later window.
// - a taken-predicted boundary-spanning branch dispatches alone that cycle.
// - the slot limit covers conditional, unconditional jumps and near calls.
// - over three tracked branches in a window evicts some predictions.
// - only branches taken at least once get an entry and count.
// - the one-byte near return is never branch-predicted.
// - a one-byte return that is a target or follows a conditional is exposed.
// - a repeat-prefixed return executes as a return but is predicted normally.
// - return targets come from a 12-entry return-address stack.
// - mismatched calls/returns or overflow desynchronise the stack, adding latency; here this only raises ras_desync, pen_cycles is unchanged.
// - beyond 12 outstanding calls, some unwinding returns mispredict.
// - in 64-bit mode the code-segment base is treated as zero.
// - penalties: 0 sequential, 1 taken, 10 mispredict, 12 with nonzero base.
`default_nettype none
package bpr_pkg;
  // ----------------------------------------------------------------
  // window and table geometry
  // ----------------------------------------------------------------
  localparam int          BPR_WIN_BYTES = 16;
  localparam int          BPR_OFF_W     = 4;
  localparam int          BPR_SLOTS     = 3;
  localparam int          BPR_RAS_DEPTH = 12;
  // ----------------------------------------------------------------
  // return opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0]  BPR_OP_RET_SHORT     = 8'hC3;
  localparam logic [7:0]  BPR_OP_REPEAT_PREFIX = 8'hF3;
  // ----------------------------------------------------------------
  // penalties in core cycles
  // ----------------------------------------------------------------
  localparam logic [3:0]  BPR_PEN_SEQ      = 4'h0;
  localparam logic [3:0]  BPR_PEN_TAKEN    = 4'h1;
  localparam logic [3:0]  BPR_PEN_MISS     = 4'hA;
  localparam logic [3:0]  BPR_PEN_MISS_SEG = 4'hC;
  // ----------------------------------------------------------------
  // branch kinds reported by decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BPR_KIND_NONE = 2'h0,
    BPR_KIND_COND = 2'h1,
    BPR_KIND_JUMP = 2'h2,
    BPR_KIND_CALL = 2'h3
  } bpr_kind_type;
endpackage
`default_nettype wire

//--- bpr_predictor.sv
// branch history store, return-address stack and penalty reporting
`default_nettype none
module bpr_predictor #(
  parameter int ADDR_W  = 32,
  parameter int ENTRIES = 16
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              lk_valid,
  input  wire logic [ADDR_W-1:0] lk_addr,
  input  wire logic [ADDR_W-1:0] lk_end,
  input  wire bpr_pkg::bpr_kind_type lk_kind,
  input  wire logic [7:0]        lk_op0,
  input  wire logic [7:0]        lk_op1,
  input  wire logic              lk_is_target,
  input  wire logic              lk_after_cond,
  output logic                   pred_valid,
  output logic                   pred_taken,
  output logic [ADDR_W-1:0]      pred_target,
  output logic                   pred_alone,
  output logic                   pred_exposed,
  input  wire logic              rs_valid,
  input  wire logic [ADDR_W-1:0] rs_end,
  input  wire bpr_pkg::bpr_kind_type rs_kind,
  input  wire logic              rs_is_ret,
  input  wire logic              rs_taken,
  input  wire logic [ADDR_W-1:0] rs_target,
  input  wire logic              rs_mispred,
  input  wire logic              mode64,
  input  wire logic              cs_base_nz,
  output logic                   pen_valid,
  output logic [3:0]             pen_cycles,
  output logic                   ras_desync
);
  localparam int IDX_W = $clog2(ENTRIES);
  localparam int TAG_W = ADDR_W - IDX_W - bpr_pkg::BPR_OFF_W;
  localparam int RP_W  = $clog2(bpr_pkg::BPR_RAS_DEPTH);
  localparam int CNT_W = RP_W + 1;
  localparam logic [RP_W-1:0]  RAS_LAST = RP_W'(bpr_pkg::BPR_RAS_DEPTH - 1);
  localparam logic [CNT_W-1:0] RAS_FULL = CNT_W'(bpr_pkg::BPR_RAS_DEPTH);
  localparam logic [1:0]       RR_LAST  = 2'(bpr_pkg::BPR_SLOTS - 1);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES || TAG_W < 1) begin : g_bad_param
    $error("bpr_predictor: ENTRIES must be a power of two leaving tag bits");
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0][bpr_pkg::BPR_SLOTS-1:0] vld_reg, vld_next;
  logic [bpr_pkg::BPR_OFF_W-1:0] off_reg [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [bpr_pkg::BPR_OFF_W-1:0] off_next [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [TAG_W-1:0]  tag_reg [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [TAG_W-1:0]  tag_next [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [ADDR_W-1:0] tgt_reg [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [ADDR_W-1:0] tgt_next [ENTRIES][bpr_pkg::BPR_SLOTS];
  logic [1:0]        rr_reg, rr_next;
  logic [ADDR_W-1:0] ras_reg [bpr_pkg::BPR_RAS_DEPTH];
  logic [ADDR_W-1:0] ras_next [bpr_pkg::BPR_RAS_DEPTH];
  logic [RP_W-1:0]   rp_reg, rp_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              dsy_reg, dsy_next;
  logic              pv_reg, pt_reg, pa_reg, pe_reg, pv_next, pt_next, pa_next, pe_next;
  logic [ADDR_W-1:0] ptgt_reg, ptgt_next;
  logic              penv_reg, penv_next;
  logic [3:0]        pen_reg, pen_next;
  // ----------------------------------------------------------------
  // window decode: last byte picks the window, so a straddler lands late
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]  lk_idx, rs_idx;
  logic [TAG_W-1:0]  lk_tag, rs_tag;
  logic [bpr_pkg::BPR_SLOTS-1:0] lk_hit, rs_hit, rs_free;
  logic [1:0]        lk_sel, rs_sel;
  logic              ret_short, ret_rep, is_push, is_pop, span;
  logic [RP_W-1:0]   top_ptr;
  assign lk_idx  = lk_end[bpr_pkg::BPR_OFF_W +: IDX_W];
  assign rs_idx  = rs_end[bpr_pkg::BPR_OFF_W +: IDX_W];
  assign lk_tag  = lk_end[ADDR_W-1 -: TAG_W];
  assign rs_tag  = rs_end[ADDR_W-1 -: TAG_W];
  assign span    = lk_addr[ADDR_W-1:bpr_pkg::BPR_OFF_W] != lk_end[ADDR_W-1:bpr_pkg::BPR_OFF_W];
  assign ret_short = lk_op0 == bpr_pkg::BPR_OP_RET_SHORT;
  assign ret_rep   = lk_op0 == bpr_pkg::BPR_OP_REPEAT_PREFIX && lk_op1 == bpr_pkg::BPR_OP_RET_SHORT;
  assign is_push = lk_valid && lk_kind == bpr_pkg::BPR_KIND_CALL;
  assign is_pop  = lk_valid && (ret_short || ret_rep);
  assign top_ptr = (rp_reg == '0) ? RAS_LAST : rp_reg - RP_W'(1);
  // per-slot compare against lookup and resolve windows
  for (genvar s = 0; s < bpr_pkg::BPR_SLOTS; s++) begin : g_slot
    assign lk_hit[s] = vld_reg[lk_idx][s] && tag_reg[lk_idx][s] == lk_tag &&
                       off_reg[lk_idx][s] == lk_end[bpr_pkg::BPR_OFF_W-1:0];
    assign rs_hit[s] = vld_reg[rs_idx][s] && tag_reg[rs_idx][s] == rs_tag &&
                       off_reg[rs_idx][s] == rs_end[bpr_pkg::BPR_OFF_W-1:0];
    assign rs_free[s] = !vld_reg[rs_idx][s];
  end
  // slot choice: hit first, else free, else round-robin victim
  always_comb begin
    lk_sel = 2'h0;
    rs_sel = rr_reg;
    for (int s = bpr_pkg::BPR_SLOTS - 1; s >= 0; s--) begin
      if (lk_hit[s]) begin
        lk_sel = 2'(s);
      end
      if (rs_hit[s] || (!(|rs_hit) && rs_free[s])) begin
        rs_sel = 2'(s);
      end
    end
  end
  // ----------------------------------------------------------------
  // branch history store update
  // ----------------------------------------------------------------
  // allocation only on a taken, tracked kind; returns live on the stack
  always_comb begin
    vld_next = vld_reg;
    off_next = off_reg;
    tag_next = tag_reg;
    tgt_next = tgt_reg;
    rr_next  = rr_reg;
    if (rs_valid && rs_taken && !rs_is_ret && rs_kind != bpr_pkg::BPR_KIND_NONE) begin
      vld_next[rs_idx][rs_sel] = 1'b1;
      off_next[rs_idx][rs_sel] = rs_end[bpr_pkg::BPR_OFF_W-1:0];
      tag_next[rs_idx][rs_sel] = rs_tag;
      tgt_next[rs_idx][rs_sel] = rs_target;
      if (!(|rs_hit) && !(|rs_free)) begin
        rr_next = (rr_reg == RR_LAST) ? 2'h0 : rr_reg + 2'h1;
      end
    end
  end
  // valid bits and victim pointer are the only table state reset needs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vld_reg <= '0;
      rr_reg  <= 2'h0;
    end else begin
      vld_reg <= vld_next;
      rr_reg  <= rr_next;
    end
  end
  // payload needs no reset: guarded by valid bits
  always_ff @(posedge core_clk) begin
    off_reg <= off_next;
    tag_reg <= tag_next;
    tgt_reg <= tgt_next;
  end
  // ----------------------------------------------------------------
  // return-address stack
  // ----------------------------------------------------------------
  // circular: a 13th push overwrites the oldest, so deep unwinds miss
  always_comb begin
    ras_next = ras_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    dsy_next = dsy_reg;
    if (is_push) begin
      ras_next[rp_reg] = lk_end + ADDR_W'(1);
      rp_next = (rp_reg == RAS_LAST) ? '0 : rp_reg + RP_W'(1);
      if (cnt_reg == RAS_FULL) begin
        dsy_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end else if (is_pop) begin
      if (cnt_reg == '0) begin
        dsy_next = 1'b1;
      end else begin
        rp_next  = top_ptr;
        cnt_next = cnt_reg - CNT_W'(1);
        dsy_next = dsy_reg && cnt_reg != CNT_W'(1); // a draining pop resyncs
      end
    end
    // mismatch seen at resolve; the set wins over the drain clear
    if (rs_valid && rs_is_ret && rs_mispred) begin
      dsy_next = 1'b1;
    end
  end
  // stack pointer, count and sync flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rp_reg  <= '0;
      cnt_reg <= '0;
      dsy_reg <= 1'b0;
    end else begin
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      dsy_reg <= dsy_next;
    end
  end
  // stack entries need no reset: the count gates pred_taken, though pred_target copies the top entry even at count zero
  always_ff @(posedge core_clk) begin
    ras_reg <= ras_next;
  end
  // ----------------------------------------------------------------
  // prediction result, one cycle after lookup
  // ----------------------------------------------------------------
  always_comb begin
    pv_next   = lk_valid;
    pt_next   = 1'b0;
    ptgt_next = ptgt_reg;
    pe_next   = 1'b0;
    if (lk_valid) begin
      if (ret_short) begin
        pe_next = lk_is_target || lk_after_cond;
      end else if (ret_rep) begin
        pt_next   = cnt_reg != '0;
        ptgt_next = ras_reg[top_ptr];
      end else if (|lk_hit) begin
        pt_next   = 1'b1;
        ptgt_next = tgt_reg[lk_idx][lk_sel];
      end
    end
    pa_next = pt_next && span;
  end
  // prediction outputs come straight from flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pv_reg   <= 1'b0;
      pt_reg   <= 1'b0;
      pa_reg   <= 1'b0;
      pe_reg   <= 1'b0;
      ptgt_reg <= '0;
    end else begin
      pv_reg   <= pv_next;
      pt_reg   <= pt_next;
      pa_reg   <= pa_next;
      pe_reg   <= pe_next;
      ptgt_reg <= ptgt_next;
    end
  end
  // ----------------------------------------------------------------
  // penalty report, one cycle after resolve
  // ----------------------------------------------------------------
  // 64-bit mode ignores the segment base entirely
  always_comb begin
    penv_next = rs_valid;
    pen_next  = pen_reg;
    if (rs_valid) begin
      if (rs_mispred) begin
        pen_next = (cs_base_nz && !mode64) ? bpr_pkg::BPR_PEN_MISS_SEG
                                           : bpr_pkg::BPR_PEN_MISS;
      end else begin
        pen_next = rs_taken ? bpr_pkg::BPR_PEN_TAKEN : bpr_pkg::BPR_PEN_SEQ;
      end
    end
  end
  // penalty pulse and held cycle count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      penv_reg <= 1'b0;
      pen_reg  <= bpr_pkg::BPR_PEN_SEQ;
    end else begin
      penv_reg <= penv_next;
      pen_reg  <= pen_next;
    end
  end
  // every output comes from a flop
  assign pred_valid   = pv_reg;
  assign pred_taken   = pt_reg;
  assign pred_target  = ptgt_reg;
  assign pred_alone   = pa_reg;
  assign pred_exposed = pe_reg;
  assign pen_valid    = penv_reg;
  assign pen_cycles   = pen_reg;
  assign ras_desync   = dsy_reg;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_short_ret_unpred: assert property (lk_valid && ret_short |=> pred_valid && !pred_taken)
    else $error("one-byte return was predicted");
  a_exposed_ret: assert property (lk_valid && ret_short && lk_after_cond |=> pred_exposed)
    else $error("exposed one-byte return not flagged");
  a_rep_ret_pred: assert property (lk_valid && ret_rep && cnt_reg != '0 |=>
      pred_taken && pred_target == $past(ras_reg[top_ptr]))
    else $error("repeat-prefixed return not predicted from stack");
  a_span_alone: assert property (lk_valid && !ret_short && !ret_rep && |lk_hit && span
      |=> pred_taken && pred_alone)
    else $error("spanning taken branch not issued alone");
  a_notaken_noalloc: assert property (rs_valid && !rs_taken |=> $stable(vld_reg))
    else $error("never-taken branch allocated");
  a_ras_bound: assert property (cnt_reg <= RAS_FULL)
    else $error("return stack count beyond depth");
  a_ras_overflow: assert property (is_push && cnt_reg == RAS_FULL |=>
      ras_desync && cnt_reg == RAS_FULL)
    else $error("overflow push did not desynchronise");
  a_pen_miss: assert property (rs_valid && rs_mispred && (!cs_base_nz || mode64)
      |=> pen_valid && pen_cycles == bpr_pkg::BPR_PEN_MISS)
    else $error("mispredict penalty not ten");
  a_pen_seg: assert property (rs_valid && rs_mispred && cs_base_nz && !mode64
      |=> pen_cycles == bpr_pkg::BPR_PEN_MISS_SEG)
    else $error("segment mispredict penalty not twelve");
  a_pen_taken: assert property (rs_valid && !rs_mispred && rs_taken
      |=> pen_cycles == bpr_pkg::BPR_PEN_TAKEN)
    else $error("taken penalty not one");
  c_btb_hit: cover property (lk_valid && |lk_hit ##1 pred_taken);
  c_ras_wrap: cover property (is_push && cnt_reg == RAS_FULL);
  c_rep_ret: cover property (lk_valid && ret_rep && cnt_reg != '0);
  c_evict: cover property (rs_valid && rs_taken && !(|rs_hit) && !(|rs_free));
endmodule
`default_nettype wire

//--- bpr_fetch_model.sv
// fetch and dispatch pipeline model that reports resolved branches
`default_nettype none
module bpr_fetch_model (
  input  wire logic             core_clk,
  output logic                  rs_valid,
  output logic [31:0]           rs_end,
  output bpr_pkg::bpr_kind_type rs_kind,
  output logic                  rs_is_ret,
  output logic                  rs_taken,
  output logic [31:0]           rs_target,
  output logic                  rs_mispred,
  output logic                  mode64,
  output logic                  cs_base_nz
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // resolve pulses
  // ----------------------------------------------------------------
  // idle values at time zero
  initial begin
    {rs_valid, rs_is_ret, rs_taken, rs_mispred, mode64, cs_base_nz} = 6'h00;
    rs_end    = 32'h0;
    rs_target = 32'h0;
    rs_kind   = bpr_pkg::BPR_KIND_NONE;
  end
  // one resolve pulse, driven at the falling edge; qualifiers other than kind and rs_is_ret are
  // scrambled afterwards so a stale value is never mistaken for a live one
  task automatic resolve(input logic [31:0] e, input bpr_pkg::bpr_kind_type k,
                         input logic tk, input logic [31:0] t,
                         input logic mp, input logic m64, input logic cs,
                         input logic ir);
    @(negedge core_clk);
    rs_valid   = 1'b1;
    rs_end     = e;
    rs_kind    = k;
    rs_is_ret  = ir;
    rs_taken   = tk;
    rs_target  = t;
    {rs_mispred, mode64, cs_base_nz} = {mp, m64, cs};
    @(negedge core_clk);
    rs_valid   = 1'b0;
    rs_end     = ~e;
    rs_target  = ~t;
    {rs_taken, rs_mispred, mode64, cs_base_nz} = ~{tk, mp, m64, cs};
  endtask
endmodule
`default_nettype wire

//--- test_branch_predictor_and_return_stack.sv
// self-checking bench for the branch predictor and return-address stack
`default_nettype none
module test_branch_predictor_and_return_stack;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk, arst_n, lk_valid, lk_is_target, lk_after_cond;
  logic [31:0]           lk_addr, lk_end, pred_target, rs_end, rs_target, a, t;
  logic [7:0]            lk_op0, lk_op1;
  bpr_pkg::bpr_kind_type lk_kind, rs_kind;
  logic                  pred_valid, pred_taken, pred_alone, pred_exposed, rs_valid;
  logic                  rs_is_ret, rs_taken, rs_mispred, mode64, cs_base_nz;
  logic                  pen_valid, ras_desync;
  logic [3:0]            pen_cycles;
  logic [31:0]           base [13];
  int                    mismatches, checks_done, hits;
  integer                seed;
  bpr_predictor #(.ADDR_W(32), .ENTRIES(16)) i_bpr_predictor (.core_clk, .arst_n,
    .lk_valid, .lk_addr, .lk_end, .lk_kind, .lk_op0, .lk_op1, .lk_is_target,
    .lk_after_cond, .pred_valid, .pred_taken, .pred_target, .pred_alone,
    .pred_exposed, .rs_valid, .rs_end, .rs_kind, .rs_is_ret, .rs_taken,
    .rs_target, .rs_mispred, .mode64, .cs_base_nz, .pen_valid, .pen_cycles,
    .ras_desync);
  bpr_fetch_model i_bpr_fetch_model (.core_clk, .rs_valid, .rs_end, .rs_kind,
    .rs_is_ret, .rs_taken, .rs_target, .rs_mispred, .mode64, .cs_base_nz);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_pen(input logic mp, tk, m64, cs);
    if (mp) return (cs && !m64) ? bpr_pkg::BPR_PEN_MISS_SEG : bpr_pkg::BPR_PEN_MISS;
    return tk ? bpr_pkg::BPR_PEN_TAKEN : bpr_pkg::BPR_PEN_SEQ;
  endfunction
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input int n);
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (n) @(negedge core_clk);
    arst_n = 1'b1;
  endtask
  // one lookup; outputs are settled at the closing falling edge
  task automatic lookup(input logic [31:0] ad, e, input bpr_pkg::bpr_kind_type k,
                        input logic [7:0] o0, o1, input logic tg, ac);
    @(negedge core_clk);
    {lk_valid, lk_is_target, lk_after_cond} = {1'b1, tg, ac};
    {lk_addr, lk_end, lk_op0, lk_op1} = {ad, e, o0, o1};
    lk_kind = k;
    @(negedge core_clk);
    lk_valid = 1'b0;
    {lk_addr, lk_end, lk_op0, lk_op1} = ~{ad, e, o0, o1};
    chk_flag(pred_valid, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // the whole run needs well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    seed = 32'h64aa26b1;
    {arst_n, lk_valid, lk_is_target, lk_after_cond} = 4'h0;
    {lk_addr, lk_end, lk_op0, lk_op1} = 80'h0;
    lk_kind = bpr_pkg::BPR_KIND_NONE;
    do_reset(16);
    chk_val(pen_cycles, 32'h0);
    chk_flag(ras_desync, 1'b0);
    // penalty for every mispredict, taken, mode and base combination
    for (int i = 0; i < 16; i++) begin
      i_bpr_fetch_model.resolve($random(seed), bpr_pkg::BPR_KIND_COND, i[0],
                                $random(seed), i[1], i[2], i[3], 1'b0);
      chk_flag(pen_valid, 1'b1);
      chk_val(pen_cycles, exp_pen(i[1], i[0], i[2], i[3]));
    end
    // allocation only on taken, straddlers go to the later window
    do_reset(2);
    a = $random(seed) & 32'hFFFF_FFC0;
    t = $random(seed);
    lookup(a, a + 1, bpr_pkg::BPR_KIND_JUMP, 8'hEB, 8'h00, 1'b0, 1'b0);
    chk_flag(pred_taken, 1'b0);
    i_bpr_fetch_model.resolve(a + 1, bpr_pkg::BPR_KIND_JUMP, 1'b0, t, 1'b0, 1'b0, 1'b0, 1'b0);
    lookup(a, a + 1, bpr_pkg::BPR_KIND_JUMP, 8'hEB, 8'h00, 1'b0, 1'b0);
    chk_flag(pred_taken, 1'b0);
    i_bpr_fetch_model.resolve(a + 1, bpr_pkg::BPR_KIND_JUMP, 1'b1, t, 1'b0, 1'b0, 1'b0, 1'b0);
    lookup(a, a + 1, bpr_pkg::BPR_KIND_JUMP, 8'hEB, 8'h00, 1'b0, 1'b0);
    chk_flag(pred_taken, 1'b1);
    chk_val(pred_target, t);
    chk_flag(pred_alone, 1'b0);
    i_bpr_fetch_model.resolve(a + 17, bpr_pkg::BPR_KIND_COND, 1'b1, ~t, 1'b0, 1'b0, 1'b0,
                              1'b0);
    lookup(a + 14, a + 17, bpr_pkg::BPR_KIND_COND, 8'h0F, 8'h84, 1'b0, 1'b0);
    chk_flag(pred_taken, 1'b1);
    chk_val(pred_target, ~t);
    chk_flag(pred_alone, 1'b1);
    // four taken branches in one window: only three keep a prediction
    for (int i = 0; i < 4; i++)
      i_bpr_fetch_model.resolve(a + 34 + 3 * i, bpr_pkg::bpr_kind_type'(i % 3 + 1),
                                1'b1, t + i, 1'b0, 1'b0, 1'b0, 1'b0);
    hits = 0;
    for (int i = 0; i < 4; i++) begin
      lookup(a + 33 + 3 * i, a + 34 + 3 * i, bpr_pkg::bpr_kind_type'(i % 3 + 1),
             8'h75, 8'h00, 1'b0, 1'b0);
      if (pred_taken === 1'b1 && pred_target === t + i) hits++;
    end
    chk_val(hits, 32'h3);
    // one-byte return: never predicted, exposed after target or conditional
    do_reset(2);
    for (int j = 0; j < 4; j++) begin
      a = $random(seed);
      lookup(a - 4, a, bpr_pkg::BPR_KIND_CALL, 8'hE8, 8'h00, 1'b0, 1'b0);
      lookup(a + 9, a + 9, bpr_pkg::BPR_KIND_NONE, 8'hC3, $random(seed), j[0], j[1]);
      chk_flag(pred_taken, 1'b0);
      chk_flag(pred_exposed, j[0] | j[1]);
    end
    // thirteen nested calls, then unwind with repeat-prefixed returns
    do_reset(2);
    for (int k = 0; k < 13; k++) begin
      base[k] = $random(seed);
      lookup(base[k] - 4, base[k], bpr_pkg::BPR_KIND_CALL, 8'hE8, 8'h00, 1'b0, 1'b0);
    end
    chk_flag(ras_desync, 1'b1);
    for (int k = 12; k > 0; k--) begin
      lookup(base[k] + 7, base[k] + 8, bpr_pkg::BPR_KIND_NONE, 8'hF3, 8'hC3, 1'b1, 1'b0);
      chk_flag(pred_taken, 1'b1);
      chk_val(pred_target, base[k] + 1);
    end
    chk_flag(ras_desync, 1'b0);
    lookup(base[0] + 7, base[0] + 8, bpr_pkg::BPR_KIND_NONE, 8'hF3, 8'hC3, 1'b0, 1'b1);
    chk_flag(pred_taken, 1'b0);
    chk_flag(ras_desync, 1'b1);
    // a resolved return mispredict desynchronises and never allocates
    do_reset(2);
    chk_flag(ras_desync, 1'b0);
    i_bpr_fetch_model.resolve(a + 72, bpr_pkg::BPR_KIND_JUMP, 1'b1, t, 1'b1, 1'b0, 1'b1,
                              1'b1);
    chk_flag(ras_desync, 1'b1);
    chk_val(pen_cycles, bpr_pkg::BPR_PEN_MISS_SEG);
    lookup(a + 70, a + 72, bpr_pkg::BPR_KIND_JUMP, 8'hEB, 8'h00, 1'b0, 1'b0);
    chk_flag(pred_taken, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
